// File: design/card_clock_gen.v
// Card clock gating and slowing engine.
// Assumes link_level, link_rise, link_fall and socket_idle already synchronised to clk.
`timescale 1ns/1ps
`include "sock_pm_defines.vh"

module card_clock_gen
(
  input  wire clk,
  input  wire rst_n,
  input  wire link_level,
  input  wire link_rise,
  input  wire link_fall,
  input  wire socket_idle,
  input  wire throttle_allow,
  input  wire slow_select,
  output reg  card_clk_out,
  output reg  clock_altered
);

  localparam [2:0] ST_RUN  = 3'h1;
  localparam [2:0] ST_STOP = 3'h2;
  localparam [2:0] ST_SLOW = 3'h4;

  reg  [2:0]               state_reg;
  reg  [2:0]               state_next;
  reg  [`SPM_IDLE_W-1:0]   idle_cnt_reg;
  reg  [`SPM_IDLE_W-1:0]   idle_cnt_next;
  reg  [`SPM_DIV_W-1:0]    div_cnt_reg;
  reg  [`SPM_DIV_W-1:0]    div_cnt_next;
  reg                      card_clk_next;
  wire                     quiet;

  // Idle window counted in card clock cycles, restarted by any activity
  always @*
  begin
    idle_cnt_next = idle_cnt_reg;
    if (!socket_idle)
      idle_cnt_next = {`SPM_IDLE_W{1'b0}};
    else if (link_rise && (idle_cnt_reg != `SPM_IDLE_CLOCKS))
      idle_cnt_next = idle_cnt_reg + {{(`SPM_IDLE_W-1){1'b0}}, 1'b1};
  end

  assign quiet = socket_idle && (idle_cnt_reg == `SPM_IDLE_CLOCKS);

  // State changes only at a card clock falling edge, so no runt pulse escapes
  always @*
  begin
    state_next    = state_reg;
    div_cnt_next  = div_cnt_reg;
    card_clk_next = card_clk_out;
    case (state_reg)
      ST_RUN:
      begin
        card_clk_next = link_level;
        div_cnt_next  = {`SPM_DIV_W{1'b0}};
        if (throttle_allow && quiet && link_fall)
        begin
          card_clk_next = 1'b0;
          if (slow_select)
            state_next = ST_SLOW;
          else
            state_next = ST_STOP;
        end
      end
      ST_STOP:
      begin
        card_clk_next = 1'b0;
        if ((!throttle_allow || !quiet || slow_select) && link_fall)
          state_next = ST_RUN;
      end
      ST_SLOW:
      begin
        if (link_rise)
        begin
          if (div_cnt_reg == `SPM_SLOW_HALF_LAST)
          begin
            div_cnt_next  = {`SPM_DIV_W{1'b0}};
            card_clk_next = ~card_clk_out;
          end
          else
            div_cnt_next = div_cnt_reg + {{(`SPM_DIV_W-1){1'b0}}, 1'b1};
        end
        if ((!throttle_allow || !quiet || !slow_select) && link_fall && !card_clk_out)
          state_next = ST_RUN;
      end
      default:
      begin
        state_next    = ST_RUN;
        card_clk_next = 1'b0;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= ST_RUN;
      idle_cnt_reg  <= {`SPM_IDLE_W{1'b0}};
      div_cnt_reg   <= {`SPM_DIV_W{1'b0}};
      card_clk_out  <= 1'b0;
      clock_altered <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      idle_cnt_reg  <= idle_cnt_next;
      div_cnt_reg   <= div_cnt_next;
      card_clk_out  <= card_clk_next;
      clock_altered <= (state_next != ST_RUN);
    end
  end

endmodule // card_clock_gen

// File: design/card_socket_clock_power_mgmt.v
// Socket power-management register with AHB-Lite slave, interrupt and clock engine.
// Assumes one AHB-Lite master, word transfers only, and a free-running card bus clock pin.
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`include "sock_pm_defines.vh"

module card_socket_clock_power_mgmt
(
  input  wire        clk,
  input  wire        rst_n,
  input  wire        socket_reset,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        card_bus_clk,
  input  wire        card_active,
  output wire        card_clk_out,
  output reg         irq
);

  // Pin synchronisers
  reg                  link_s1_reg;
  reg                  link_s2_reg;
  reg                  link_s3_reg;
  reg                  act_s1_reg;
  reg                  act_s2_reg;
  reg                  act_s3_reg;
  wire                 link_rise;
  wire                 link_fall;
  wire                 access_event;

  // Bus pipeline
  reg                  dp_write_reg;
  reg  [`SPM_ADDR_W-1:0] dp_addr_reg;
  wire                 accept;
  wire                 rd_accept;
  wire                 wr_commit;
  wire [`SPM_ADDR_W-1:0] a_addr;
  wire                 ctrl_wr;
  wire                 mask_wr;
  wire                 allow_now;
  wire                 slow_now;
  wire [`SPM_IRQ_W-1:0] mask_now;

  // Register state
  reg                  allow_reg;
  reg                  slow_reg;
  reg                  access_seen_reg;
  reg  [`SPM_IRQ_W-1:0] irq_stat_reg;
  reg  [`SPM_IRQ_W-1:0] irq_stat_next;
  reg  [`SPM_IRQ_W-1:0] irq_mask_reg;
  reg                  altered_d_reg;
  wire                 clock_altered;
  wire                 change_event;
  wire [`SPM_IRQ_W-1:0] irq_events;

  // Read value of the register at one offset
  function [31:0] read_word;
    input [`SPM_ADDR_W-1:0] addr;
    input                   allow_v;
    input                   slow_v;
    input                   seen_v;
    input                   changed_v;
    input [`SPM_IRQ_W-1:0]  stat_v;
    input [`SPM_IRQ_W-1:0]  mask_v;
    begin
      read_word = `SPM_DATA_ZERO;
      case (addr)
        `SPM_CTRL_OFFSET:
        begin
          read_word[`SPM_ACCESS_BIT]  = seen_v;
          read_word[`SPM_CHANGED_BIT] = changed_v;
          read_word[`SPM_ALLOW_BIT]   = allow_v;
          read_word[`SPM_SLOW_BIT]    = slow_v;
        end
        `SPM_IRQ_STAT_OFFSET:
          read_word[`SPM_IRQ_W-1:0] = stat_v;
        `SPM_IRQ_MASK_OFFSET:
          read_word[`SPM_IRQ_W-1:0] = mask_v;
        default:
          read_word = `SPM_DATA_ZERO;
      endcase
    end
  endfunction

  // Card bus clock and activity come from outside the clk domain
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      link_s1_reg <= 1'b0;
      link_s2_reg <= 1'b0;
      link_s3_reg <= 1'b0;
      act_s1_reg  <= 1'b0;
      act_s2_reg  <= 1'b0;
      act_s3_reg  <= 1'b0;
    end
    else
    begin
      link_s1_reg <= card_bus_clk;
      link_s2_reg <= link_s1_reg;
      link_s3_reg <= link_s2_reg;
      act_s1_reg  <= card_active;
      act_s2_reg  <= act_s1_reg;
      act_s3_reg  <= act_s2_reg;
    end
  end

  assign link_rise    = link_s2_reg && !link_s3_reg;
  assign link_fall    = !link_s2_reg && link_s3_reg;
  assign access_event = act_s2_reg && !act_s3_reg;

  // AHB-Lite address phase and data phase
  assign accept    = hsel && htrans[`SPM_HTRANS_ACTIVE] && hready;
  assign rd_accept = accept && !hwrite;
  assign a_addr    = haddr[`SPM_ADDR_W-1:0];
  assign wr_commit = dp_write_reg;

  // A read right behind a write sees the value that write is committing
  assign ctrl_wr   = wr_commit && (dp_addr_reg == `SPM_CTRL_OFFSET);
  assign mask_wr   = wr_commit && (dp_addr_reg == `SPM_IRQ_MASK_OFFSET);
  assign allow_now = !socket_reset && (ctrl_wr ? hwdata[`SPM_ALLOW_BIT] : allow_reg);
  assign slow_now  = !socket_reset && (ctrl_wr ? hwdata[`SPM_SLOW_BIT] : slow_reg);
  assign mask_now  = socket_reset ? `SPM_IRQ_RESET :
                     (mask_wr ? hwdata[`SPM_IRQ_W-1:0] : irq_mask_reg);

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= {`SPM_ADDR_W{1'b0}};
      hreadyout    <= 1'b1;
      hresp        <= `SPM_HRESP_OKAY;
      hrdata       <= `SPM_DATA_ZERO;
    end
    else
    begin
      hreadyout    <= 1'b1;
      hresp        <= `SPM_HRESP_OKAY;
      dp_write_reg <= accept && hwrite;
      if (accept)
        dp_addr_reg <= a_addr;
      if (rd_accept)
        hrdata <= read_word(a_addr, allow_now, slow_now, access_seen_reg,
                            clock_altered, irq_stat_reg, mask_now);
      else
        hrdata <= `SPM_DATA_ZERO;
    end
  end

  // Control bits: written by software, cleared by either reset
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      allow_reg    <= 1'b0;
      slow_reg     <= 1'b0;
      irq_mask_reg <= `SPM_IRQ_RESET;
    end
    else if (socket_reset)
    begin
      allow_reg    <= 1'b0;
      slow_reg     <= 1'b0;
      irq_mask_reg <= `SPM_IRQ_RESET;
    end
    else if (wr_commit)
    begin
      if (dp_addr_reg == `SPM_CTRL_OFFSET)
      begin
        allow_reg <= hwdata[`SPM_ALLOW_BIT];
        slow_reg  <= hwdata[`SPM_SLOW_BIT];
      end
      if (dp_addr_reg == `SPM_IRQ_MASK_OFFSET)
        irq_mask_reg <= hwdata[`SPM_IRQ_W-1:0];
    end
  end

  // Access flag: only the global reset clears it besides a read; a new access wins
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      access_seen_reg <= 1'b0;
    else if (access_event)
      access_seen_reg <= 1'b1;
    else if (rd_accept && (a_addr == `SPM_CTRL_OFFSET))
      access_seen_reg <= 1'b0;
  end

  // Sticky interrupt events, cleared by a read of the status register
  assign change_event = clock_altered != altered_d_reg;
  assign irq_events   = {change_event, access_event};

  always @*
  begin
    irq_stat_next = irq_stat_reg;
    if (rd_accept && (a_addr == `SPM_IRQ_STAT_OFFSET))
      irq_stat_next = `SPM_IRQ_RESET;
    irq_stat_next = irq_stat_next | irq_events;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_reg  <= `SPM_IRQ_RESET;
      altered_d_reg <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      irq_stat_reg  <= irq_stat_next;
      altered_d_reg <= clock_altered;
      irq           <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // Clock engine: throttling honoured only while allowed
  card_clock_gen u_clock_gen
  (
    .clk            (clk),
    .rst_n          (rst_n),
    .link_level     (link_s2_reg),
    .link_rise      (link_rise),
    .link_fall      (link_fall),
    .socket_idle    (!act_s2_reg),
    .throttle_allow (allow_reg),
    .slow_select    (slow_reg),
    .card_clk_out   (card_clk_out),
    .clock_altered  (clock_altered)
  );

endmodule // card_socket_clock_power_mgmt

// File: design/sock_pm_defines.vh
// Constants for the socket clock power-management block.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef SOCK_PM_DEFINES_VH
`define SOCK_PM_DEFINES_VH

// Register byte offsets (low address byte)
`define SPM_ADDR_W          8
`define SPM_CTRL_OFFSET     8'h20
`define SPM_IRQ_STAT_OFFSET 8'h24
`define SPM_IRQ_MASK_OFFSET 8'h28

// Power-management register fields
`define SPM_ACCESS_BIT      25
`define SPM_CHANGED_BIT     24
`define SPM_ALLOW_BIT       16
`define SPM_SLOW_BIT        0
`define SPM_CTRL_RESET      32'h00000000

// Interrupt status / mask fields
`define SPM_IRQ_W           2
`define SPM_IRQ_ACCESS_BIT  0
`define SPM_IRQ_CHANGE_BIT  1
`define SPM_IRQ_RESET       2'h0

// AHB-Lite encodings
`define SPM_HTRANS_ACTIVE   1
`define SPM_HRESP_OKAY      1'h0
`define SPM_DATA_ZERO       32'h00000000

// Card clock control timing, in card clock cycles
`define SPM_IDLE_W          4
`define SPM_IDLE_CLOCKS     4'h8
`define SPM_DIV_W           3
`define SPM_SLOW_HALF_LAST  3'h7

`endif

// File: verif/card_model.sv
// Card side: free-running card bus clock and the card activity level.
// Assumes the bench raises busy while the card is in use.
`timescale 1ns/1ps
module card_model
(
  input  wire busy,
  output reg  card_bus_clk,
  output wire card_active
);
  assign card_active = busy;
  initial
  begin
    card_bus_clk = 1'b0;
    forever #100 card_bus_clk = ~card_bus_clk;
  end
endmodule // card_model

// File: verif/sock_pm_properties.sv
// Checker bound to the socket power-management block.
// Assumes one bus master and card_active low as socket idle.
`timescale 1ns/1ps
module sock_pm_props
(
  input wire        clk,
  input wire        rst_n,
  input wire        socket_reset,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire [31:0] hrdata,
  input wire        card_bus_clk,
  input wire        card_active,
  input wire        card_clk_out
);
  wire       take = hsel && htrans[1] && hready;
  wire       hit  = haddr[7:0] == 8'h20;
  reg        rd_any;
  reg        rd_dp;
  reg        wr_dp;
  reg        allow_q;
  reg        slow_q;
  reg        bclk_q;
  reg        act_q;
  reg  [7:0] rise_age;
  reg  [7:0] low_cnt;
  reg  [3:0] edges;
  reg  [3:0] since_rd;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow control bits, time since activity and time the card clock is low
  always @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rd_any   <= 1'b0;
      rd_dp    <= 1'b0;
      wr_dp    <= 1'b0;
      allow_q  <= 1'b0;
      slow_q   <= 1'b0;
      bclk_q   <= 1'b0;
      act_q    <= 1'b0;
      rise_age <= 8'h00;
      low_cnt  <= 8'h00;
      edges    <= 4'h0;
      since_rd <= 4'hF;
    end
    else
    begin
      rd_any   <= take && !hwrite;
      rd_dp    <= take && !hwrite && hit;
      wr_dp    <= take && hwrite && hit;
      allow_q  <= socket_reset ? 1'b0 : (wr_dp ? hwdata[16] : allow_q);
      slow_q   <= socket_reset ? 1'b0 : (wr_dp ? hwdata[0] : slow_q);
      bclk_q   <= card_bus_clk;
      act_q    <= card_active;
      rise_age <= (card_active && !act_q) ? 8'h00 : rise_age + {7'h00, rise_age != 8'hFF};
      low_cnt  <= card_clk_out ? 8'h00 : low_cnt + {7'h00, low_cnt != 8'hFF};
      edges    <= card_active ? 4'h0 : edges + {3'h0, card_bus_clk && !bclk_q && edges != 4'hF};
      since_rd <= rd_dp ? 4'h0 : since_rd + {3'h0, since_rd != 4'hF};
    end
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  chk_reserved_zero: assert property (rd_dp |-> hrdata[31:26] == 6'h00 &&
    hrdata[23:17] == 7'h00 && hrdata[15:1] == 15'h0000)
    else $error("reserved bits set");
  chk_idle_data: assert property (!rd_any |-> hrdata == 32'h00000000)
    else $error("read data outside data phase");
  chk_ctrl_readback: assert property (rd_dp |-> hrdata[16] == allow_q &&
    hrdata[0] == slow_q)
    else $error("control bits differ from last write");
  chk_seen_clear: assert property (rd_dp && since_rd <= 4'h4 && rise_age >= 8'h08
    |-> !hrdata[25])
    else $error("access flag not cleared by read");
  chk_changed_flag: assert property (rd_dp && low_cnt >= 8'h28 |-> hrdata[24])
    else $error("clock change not reported");
  chk_idle_wait: assert property (low_cnt == 8'h14 && rise_age >= 8'h18
    |-> edges >= 4'h8)
    else $error("card clock held before idle count");
  chk_full_rate: assert property (low_cnt == 8'h14 |-> allow_q)
    else $error("card clock held while not allowed");
endmodule // sock_pm_props

bind card_socket_clock_power_mgmt sock_pm_props chk_u
(
  .clk, .rst_n, .socket_reset, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hreadyout, .hresp, .hrdata, .card_bus_clk, .card_active, .card_clk_out
);

// File: verif/tb_top.sv
// Bench for the socket power-management block with the card model.
// Assumes a zero-wait bus slave and a 200 ns card bus clock.
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         socket_reset = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h00000000;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h00000000;
  reg         busy = 1'b1;
  wire        hready;
  wire        hresp;
  wire [31:0] hrdata;
  wire        card_bus_clk;
  wire        card_active;
  wire        card_clk_out;
  wire        irq;
  reg  [31:0] rd;
  integer     n;
  integer     fail_count = 0;
  integer     compares = 0;
  card_socket_clock_power_mgmt dut_u
  (
    .clk, .rst_n, .socket_reset, .hsel, .haddr, .htrans, .hwrite, .hsize (3'h2),
    .hwdata, .hready, .hreadyout (hready), .hresp, .hrdata, .card_bus_clk,
    .card_active, .card_clk_out, .irq
  );
  card_model card_u (.busy, .card_bus_clk, .card_active);
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  task chk(input string what, input [31:0] exp, input [31:0] got);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("unexpected %0s: expected %h, seen %h", what, exp, got);
    end
  end
  endtask
  task ahb(input w, input [7:0] a, input [31:0] wd);
  begin
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  end
  endtask
  task rdx(input [7:0] a, input [31:0] m, input [31:0] e, input string what);
  begin
    ahb(1'b0, a, 32'h00000000);
    chk(what, e, rd & m);
  end
  endtask
  task rises(input integer cyc);
    reg prev;
  begin
    n = 0;
    prev = card_clk_out;
    repeat (cyc)
    begin
      @(posedge clk);
      if (card_clk_out && !prev)
        n = n + 1;
      prev = card_clk_out;
    end
  end
  endtask
  // Short idle gap then a card access
  task blip;
  begin
    busy <= 1'b0;
    repeat (8) @(posedge clk);
    busy <= 1'b1;
    repeat (8) @(posedge clk);
  end
  endtask
  task t_regs;
  begin
    rdx(8'h20, 32'hFFFFFFFF, 32'h00000000, "ctrl reset");
    rdx(8'h34, 32'hFFFFFFFF, 32'h00000000, "unmapped");
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    rdx(8'h20, 32'hFCFFFFFF, 32'h00010001, "ctrl bits");
  end
  endtask
  // Write and read of the control word back to back on the bus
  task t_pipe;
  begin
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= 32'h00000020;
    hwrite <= 1'b1;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hwrite <= 1'b0;
    hwdata <= 32'h00010000;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    chk("write then read", 32'h00010000, hrdata & 32'h00010001);
  end
  endtask
  task t_irq;
  begin
    ahb(1'b1, 8'h28, 32'h00000001);
    ahb(1'b0, 8'h24, 32'h00000000);
    blip;
    chk("irq raised", 32'h1, {31'h0, irq});
    rdx(8'h24, 32'h00000001, 32'h00000001, "access status");
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    socket_reset <= 1'b1;
    @(posedge clk);
    socket_reset <= 1'b0;
    rdx(8'h20, 32'h02010001, 32'h02000000, "seen kept");
    rdx(8'h20, 32'h02000000, 32'h00000000, "seen cleared");
    blip;
    chk("irq masked", 32'h0, {31'h0, irq});
    rdx(8'h24, 32'h00000001, 32'h00000001, "masked status");
  end
  endtask
  task t_clock;
  begin
    ahb(1'b1, 8'h20, 32'h00000001);
    busy <= 1'b0;
    rises(240);
    chk("full rate", 32'h1, {31'h0, n >= 28});
    rdx(8'h20, 32'h01000000, 32'h00000000, "clock normal");
    busy <= 1'b1;
    repeat (8) @(posedge clk);
    ahb(1'b1, 8'h20, 32'h00010000);
    busy <= 1'b0;
    rises(400);
    chk("edges before stop", 32'h1, {31'h0, n >= 8 && n <= 9});
    rdx(8'h20, 32'h01000000, 32'h01000000, "clock stopped");
    busy <= 1'b1;
    rises(120);
    chk("clock resumed", 32'h1, {31'h0, n >= 13});
    rdx(8'h20, 32'h01000000, 32'h00000000, "clock restored");
    ahb(1'b1, 8'h20, 32'h00010001);
    busy <= 1'b0;
    repeat (120) @(posedge clk);
    while (card_clk_out !== 1'b1) @(posedge clk);
    n = 0;
    while (card_clk_out === 1'b1)
    begin
      @(posedge clk);
      n = n + 1;
    end
    chk("slow half period", 32'h1, {31'h0, n >= 60 && n <= 68});
    rdx(8'h20, 32'h01000000, 32'h01000000, "clock slowed");
  end
  endtask
  task wrap_up;
  begin
    if (fail_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_regs;
    t_pipe;
    t_irq;
    t_clock;
    wrap_up;
  end
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    wrap_up;
  end
endmodule // tb_top
